/* shared/dti_pkg.sv */
// Constants and the register select type for the dual timer interrupt register block
package dti_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] PENDING_OFFSET = 16'h4614;
  localparam logic [ADDR_W-1:0] ENABLE_OFFSET = 16'h462c;
  localparam int REG_W = 16;
  localparam logic [REG_W-1:0] PENDING_RESET = 16'h0000;
  localparam logic [REG_W-1:0] ENABLE_RESET = 16'h0000;
  // Bits 15 and 7 are reserved and read zero
  localparam logic [REG_W-1:0] LIVE_BITS = 16'h7f7f;

  // ----------------------------------------------------------------
  // Field positions, timer 1 in the low byte, timer 2 in the high byte
  // ----------------------------------------------------------------
  localparam int T1_OVERFLOW_BIT = 0;
  localparam int T1_COMPARE_A_BIT = 1;
  localparam int T1_COMPARE_B_BIT = 2;
  localparam int T1_ZERO_MATCH_BIT = 3;
  localparam int T1_TOP_MATCH_BIT = 4;
  localparam int T1_CAPTURE_A_BIT = 5;
  localparam int T1_CAPTURE_B_BIT = 6;
  localparam int T2_OVERFLOW_BIT = 8;
  localparam int T2_COMPARE_A_BIT = 9;
  localparam int T2_COMPARE_B_BIT = 10;
  localparam int T2_ZERO_MATCH_BIT = 11;
  localparam int T2_TOP_MATCH_BIT = 12;
  localparam int T2_CAPTURE_A_BIT = 13;
  localparam int T2_CAPTURE_B_BIT = 14;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Register selected by a byte address
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_PENDING,
    SEL_ENABLE
  } dti_sel_e;

endpackage : dti_pkg

/* hdl/dti_flag_bank.sv */
// Sticky pending-flag bank with set priority over clear
`timescale 1ns/1ns
`default_nettype none
module dti_flag_bank (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [dti_pkg::REG_W-1:0] set_bits,
  input wire logic [dti_pkg::REG_W-1:0] clear_bits,
  output logic [dti_pkg::REG_W-1:0] flags_q
);

  // ----------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------
  logic [dti_pkg::REG_W-1:0] flags_d;

  // Clear first, then set, so an event in the clearing cycle survives
  always_comb begin
    flags_d = (flags_q & ~clear_bits) | set_bits;
    flags_d = flags_d & dti_pkg::LIVE_BITS;
  end

  // Synchronous reset to all clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_q <= dti_pkg::PENDING_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule : dti_flag_bank
`default_nettype wire

/* hdl/dti_timer_irq_regs.sv */
// Timer interrupt enable and pending registers behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module dti_timer_irq_regs (
  input wire logic ref_clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dti_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [dti_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Timer 1 events
  input wire logic t1_overflow_event,
  input wire logic t1_compare_a_event,
  input wire logic t1_compare_b_event,
  input wire logic t1_zero_match_event,
  input wire logic t1_top_match_event,
  input wire logic t1_capture_a_event,
  input wire logic t1_capture_b_event,
  // Timer 2 events
  input wire logic t2_overflow_event,
  input wire logic t2_compare_a_event,
  input wire logic t2_compare_b_event,
  input wire logic t2_zero_match_event,
  input wire logic t2_top_match_event,
  input wire logic t2_capture_a_event,
  input wire logic t2_capture_b_event,
  // Interrupt request to the processor
  output logic timer_irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Map a byte address onto a register
  function automatic dti_pkg::dti_sel_e decode_addr(input logic [dti_pkg::ADDR_W-1:0] addr);
    if (addr == dti_pkg::PENDING_OFFSET) begin
      return dti_pkg::SEL_PENDING;
    end else if (addr == dti_pkg::ENABLE_OFFSET) begin
      return dti_pkg::SEL_ENABLE;
    end else begin
      return dti_pkg::SEL_NONE;
    end
  endfunction : decode_addr

  // Bits of the 16-bit register covered by the active byte lanes
  function automatic logic [dti_pkg::REG_W-1:0] lane_bits(input logic [3:0] strb);
    return {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_bits

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic aw_held_q;
  logic [dti_pkg::ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [dti_pkg::REG_W-1:0] enable_q;
  logic [dti_pkg::REG_W-1:0] pending_q;
  logic [dti_pkg::REG_W-1:0] event_bits;
  logic [dti_pkg::REG_W-1:0] wr_clear_bits;
  logic [dti_pkg::REG_W-1:0] rd_clear_bits;
  logic [dti_pkg::REG_W-1:0] write_lanes;
  logic [dti_pkg::REG_W-1:0] read_value;
  dti_pkg::dti_sel_e wr_sel;
  dti_pkg::dti_sel_e rd_sel;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic ar_take;

  // ----------------------------------------------------------------
  // Event gathering
  // ----------------------------------------------------------------

  // Place each timer event at its flag position, reserved bits stay zero
  always_comb begin
    event_bits = '0;
    event_bits[dti_pkg::T1_OVERFLOW_BIT] = t1_overflow_event;
    event_bits[dti_pkg::T1_COMPARE_A_BIT] = t1_compare_a_event;
    event_bits[dti_pkg::T1_COMPARE_B_BIT] = t1_compare_b_event;
    event_bits[dti_pkg::T1_ZERO_MATCH_BIT] = t1_zero_match_event;
    event_bits[dti_pkg::T1_TOP_MATCH_BIT] = t1_top_match_event;
    event_bits[dti_pkg::T1_CAPTURE_A_BIT] = t1_capture_a_event;
    event_bits[dti_pkg::T1_CAPTURE_B_BIT] = t1_capture_b_event;
    event_bits[dti_pkg::T2_OVERFLOW_BIT] = t2_overflow_event;
    event_bits[dti_pkg::T2_COMPARE_A_BIT] = t2_compare_a_event;
    event_bits[dti_pkg::T2_COMPARE_B_BIT] = t2_compare_b_event;
    event_bits[dti_pkg::T2_ZERO_MATCH_BIT] = t2_zero_match_event;
    event_bits[dti_pkg::T2_TOP_MATCH_BIT] = t2_top_match_event;
    event_bits[dti_pkg::T2_CAPTURE_A_BIT] = t2_capture_a_event;
    event_bits[dti_pkg::T2_CAPTURE_B_BIT] = t2_capture_b_event;
  end

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------

  // Each of address and data is taken alone, and refused while held
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_sel = decode_addr(aw_addr_q);
  assign write_lanes = lane_bits(w_strb_q);

  // Write address holding register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  // Write data holding register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response, error for an address outside the map
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= dti_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_sel == dti_pkg::SEL_NONE) ? dti_pkg::RESP_DECERR : dti_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------------------------------
  // Enable mask register
  // ----------------------------------------------------------------

  // Software write, per byte lane, reserved bits held at zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enable_q <= dti_pkg::ENABLE_RESET;
    end else if (wr_fire && wr_sel == dti_pkg::SEL_ENABLE) begin
      enable_q <= ((enable_q & ~write_lanes)
                  | (w_data_q[dti_pkg::REG_W-1:0] & write_lanes))
                  & dti_pkg::LIVE_BITS;
    end
  end

  // ----------------------------------------------------------------
  // Pending flag register
  // ----------------------------------------------------------------

  // A one written to a pending bit clears it
  always_comb begin
    wr_clear_bits = '0;
    if (wr_fire && wr_sel == dti_pkg::SEL_PENDING) begin
      wr_clear_bits = w_data_q[dti_pkg::REG_W-1:0] & write_lanes;
    end
  end

  // A read clears exactly the bits it returns
  always_comb begin
    rd_clear_bits = '0;
    if (ar_take && rd_sel == dti_pkg::SEL_PENDING) begin
      rd_clear_bits = pending_q;
    end
  end

  // Sticky storage, new events win over either clear
  dti_flag_bank u_flags (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_bits(event_bits),
    .clear_bits(wr_clear_bits | rd_clear_bits),
    .flags_q(pending_q)
  );

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------

  // One read at a time, refused while the answer waits
  assign s_axi_arready = !rvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_sel = decode_addr(s_axi_araddr);

  // Select the register contents for the read
  always_comb begin
    read_value = '0;
    unique case (rd_sel)
      dti_pkg::SEL_PENDING: read_value = pending_q;
      dti_pkg::SEL_ENABLE: read_value = enable_q;
      dti_pkg::SEL_NONE: read_value = '0;
    endcase
  end

  // Registered read answer, upper half reads zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= dti_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {16'h0000, read_value};
      rresp_q <= (rd_sel == dti_pkg::SEL_NONE) ? dti_pkg::RESP_DECERR : dti_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------

  // Raised while any pending bit has its enable set
  assign timer_irq = |(pending_q & enable_q);

endmodule : dti_timer_irq_regs
`default_nettype wire

/* tb/dti_regs_chk.sv */
// Concurrent checks on the timer interrupt register block ports
`timescale 1ns/1ns
`default_nettype none
module dti_regs_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [dti_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic t2_top_match_event,
  input wire logic t2_zero_match_event,
  input wire logic t2_capture_a_event,
  input wire logic timer_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Read of the pending register taken now
  logic rd_pend;
  assign rd_pend = s_axi_arvalid && s_axi_arready && s_axi_araddr == dti_pkg::PENDING_OFFSET;
  chk_rsv_bits: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[7])
    else $error("reserved read bits set");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_top_flag: assert property ($past(rst_n) && $past(t2_top_match_event) && rd_pend |=> s_axi_rdata[12])
    else $error("top match flag missing");
  chk_zero_flag: assert property ($past(rst_n) && $past(t2_zero_match_event) && rd_pend |=> s_axi_rdata[11])
    else $error("zero match flag missing");
  chk_capa_flag: assert property ($past(rst_n) && $past(t2_capture_a_event) && rd_pend |=> s_axi_rdata[13])
    else $error("capture flag missing");
  chk_irq_reset: assert property ($rose(rst_n) |-> !timer_irq ##1 !timer_irq)
    else $error("request after reset");
endmodule : dti_regs_chk
bind dti_timer_irq_regs dti_regs_chk u_chk (.*);
`default_nettype wire

/* tb/dti_irq_host.sv */
// Processor-side model that counts cycles of interrupt request
`timescale 1ns/1ns
`default_nettype none
module dti_irq_host (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic timer_irq,
  output logic [15:0] irq_cycles_q
);
  // Count cycles with the request raised
  always_ff @(posedge ref_clk) begin
    if (!rst_n) irq_cycles_q <= 16'h0;
    else if (timer_irq) irq_cycles_q <= irq_cycles_q + 16'h1;
  end
endmodule : dti_irq_host
`default_nettype wire

/* tb/dual_timer_interrupt_regs_bench.sv */
// Self-checking bench for the timer interrupt register block
`timescale 1ns/1ns
`default_nettype none
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH %0t %h %h", $time, (a), (b)); end end
module dual_timer_interrupt_regs_bench;
  logic ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [15:0] awaddr, araddr, ev, pend_m, en_m, irq_cycles;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb;
  logic slow_b;
  logic [1:0] bresp, rresp;
  int bad_count, num_checks;
  dti_timer_irq_regs dut (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .t1_overflow_event(ev[0]), .t1_compare_a_event(ev[1]), .t1_compare_b_event(ev[2]),
    .t1_zero_match_event(ev[3]), .t1_top_match_event(ev[4]), .t1_capture_a_event(ev[5]),
    .t1_capture_b_event(ev[6]), .t2_overflow_event(ev[8]), .t2_compare_a_event(ev[9]),
    .t2_compare_b_event(ev[10]), .t2_zero_match_event(ev[11]), .t2_top_match_event(ev[12]),
    .t2_capture_a_event(ev[13]), .t2_capture_b_event(ev[14]), .timer_irq(irq)
  );
  dti_irq_host host (.ref_clk(ref_clk), .rst_n(rst_n), .timer_irq(irq), .irq_cycles_q(irq_cycles));
  // Next pseudo-random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h00400007 : 32'h0);
  endfunction : lfsr
  // Expected read word of a register model value
  function automatic logic [31:0] exp_word(input logic [15:0] v);
    return {16'h0, v & dti_pkg::LIVE_BITS};
  endfunction : exp_word
  // Bus write, both channels offered together
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] rsp);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow_b;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge ref_clk); while (!bvalid);
    // Late response acceptance, the answer must stand meanwhile
    if (!bready) begin
      bready <= 1'b1;
      @(posedge ref_clk);
    end
    `CK(bresp, rsp)
    bready <= 1'b0;
  endtask : wr
  // Bus read and compare
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] rsp);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    `CK(rdata, exp)
    `CK(rresp, rsp)
    rready <= 1'b0;
  endtask : rd
  // One-cycle event pulse, then request check
  task automatic pulse(input logic [15:0] v);
    @(posedge ref_clk);
    ev <= v;
    pend_m = pend_m | v;
    @(posedge ref_clk);
    ev <= 16'h0;
    @(posedge ref_clk);
    `CK(irq, |(pend_m & en_m & dti_pkg::LIVE_BITS))
  endtask : pulse
  // Verdict
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Watchdog
  initial begin
    #2000000;
    bad_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, ev, pend_m, en_m} = 80'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    seed = 32'h9e3ef04a;
    slow_b = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(dti_pkg::ENABLE_OFFSET, 32'h0, dti_pkg::RESP_OKAY);
    rd(dti_pkg::PENDING_OFFSET, 32'h0, dti_pkg::RESP_OKAY);
    // Walk each source alone, reserved bits too
    for (int i = 0; i < 16; i++) begin
      pulse(16'h1 << i);
      rd(dti_pkg::PENDING_OFFSET, exp_word(pend_m), dti_pkg::RESP_OKAY);
      pend_m = 16'h0;
      rd(dti_pkg::PENDING_OFFSET, 32'h0, dti_pkg::RESP_OKAY);
    end
    // Random masks, events and clears
    for (int k = 0; k < 40; k++) begin
      seed = lfsr(seed);
      en_m = seed[15:0];
      slow_b = seed[16];
      wr(dti_pkg::ENABLE_OFFSET, seed, dti_pkg::RESP_OKAY);
      rd(dti_pkg::ENABLE_OFFSET, exp_word(en_m), dti_pkg::RESP_OKAY);
      seed = lfsr(seed);
      pulse(seed[15:0]);
      seed = lfsr(seed);
      wr(dti_pkg::PENDING_OFFSET, {16'h0, seed[15:0]}, dti_pkg::RESP_OKAY);
      pend_m = pend_m & ~seed[15:0];
      `CK(irq, |(pend_m & en_m & dti_pkg::LIVE_BITS))
      rd(dti_pkg::PENDING_OFFSET, exp_word(pend_m), dti_pkg::RESP_OKAY);
      pend_m = 16'h0;
    end
    // Events held across a pending read, the set wins over the read clear
    ev <= 16'h7800;
    rd(dti_pkg::PENDING_OFFSET, 32'h00007800, dti_pkg::RESP_OKAY);
    ev <= 16'h0000;
    `CK(irq, |(16'h7800 & en_m))
    rd(dti_pkg::PENDING_OFFSET, 32'h00007800, dti_pkg::RESP_OKAY);
    `CK(irq, 1'b0)
    rd(dti_pkg::PENDING_OFFSET, 32'h0, dti_pkg::RESP_OKAY);
    // Upper lane only, then unmapped place
    wstrb <= 4'h2;
    wr(dti_pkg::ENABLE_OFFSET, 32'h0000ffff, dti_pkg::RESP_OKAY);
    en_m = en_m | 16'hff00;
    wstrb <= 4'hf;
    rd(dti_pkg::ENABLE_OFFSET, exp_word(en_m), dti_pkg::RESP_OKAY);
    wr(16'h4618, 32'h0, dti_pkg::RESP_DECERR);
    rd(16'h4618, 32'h0, dti_pkg::RESP_DECERR);
    rd(dti_pkg::ENABLE_OFFSET, exp_word(en_m), dti_pkg::RESP_OKAY);
    `CK(irq_cycles != 16'h0, 1'b1)
    // Reset in mid-run clears both registers and the request
    pulse(16'h0101);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    pend_m = 16'h0;
    en_m = 16'h0;
    rd(dti_pkg::ENABLE_OFFSET, 32'h0, dti_pkg::RESP_OKAY);
    rd(dti_pkg::PENDING_OFFSET, 32'h0, dti_pkg::RESP_OKAY);
    `CK(irq, 1'b0)
    finish_test();
  end
endmodule : dual_timer_interrupt_regs_bench
`default_nettype wire
